//--- src/fieldbus_adapter_diagnostics.sv
// Purpose: Status indicators and internal error registers of a fieldbus adapter.
// Assumes: Inputs are synchronous to clock; query.done pulses once per query.
// Notes:   Orange is shown as green and red lit together.
`timescale 1ns/10ps
`default_nettype none

module fieldbus_adapter_diagnostics #(
	parameter int unsigned BLINK_COUNT = fieldbus_diag_pkg::BLINK_CYCLES,
	parameter int unsigned CLOCK_HZ    = fieldbus_diag_pkg::CLK_HZ
) (
	input  wire logic                          clock,
	input  wire logic                          rstn,
	input  wire fieldbus_diag_pkg::status_in_t status,
	input  wire logic [2:0]                    rate_sel,
	input  wire fieldbus_diag_pkg::query_t     query,
	input  wire fieldbus_diag_pkg::reg_req_t   reg_req,
	output var  logic [15:0]                   reg_rdata,
	output var  logic                          reg_rvalid,
	output var  logic                          bit_tick,
	output var  fieldbus_diag_pkg::led_t       host_led,
	output var  fieldbus_diag_pkg::led_t       module_led,
	output var  fieldbus_diag_pkg::led_t       network_led
);
	import fieldbus_diag_pkg::*;

	// ==========================================================================
	// Helpers.

	// True when the register number lies in the 32-bit parameter area.
	function automatic logic in_area32(input logic [15:0] r);
		in_area32 = (r >= AREA32_BASE) && (r <= AREA32_LAST);
	endfunction

	// Parameter group of a register number in either area.
	function automatic logic [15:0] group_of(input logic [15:0] r);
		if (in_area32(r)) begin
			group_of = (r - AREA32_BASE) / GROUP32_SPAN;
		end else begin
			group_of = r / GROUP16_SPAN;
		end
	endfunction

	// Bit-period divisor for a rate select code; unknown codes fall back to the slowest.
	function automatic logic [DIV_W-1:0] divisor(input logic [2:0] sel);
		int unsigned rate;
		rate = BAUD_9K6;
		case (sel)
			RATE_19K2: begin
				rate = BAUD_19K2;
			end
			RATE_38K4: begin
				rate = BAUD_38K4;
			end
			RATE_57K6: begin
				rate = BAUD_57K6;
			end
			RATE_115K2: begin
				rate = BAUD_115K2;
			end
			default: begin
				rate = BAUD_9K6;
			end
		endcase
		divisor = DIV_W'(CLOCK_HZ / rate - 1);
	endfunction

	// ==========================================================================
	// State of the block.
	typedef struct packed {
		host_link_t  link;
		logic [26:0] blink_cnt;
		logic        phase;
		logic        fs_latched;
		logic [DIV_W-1:0] bit_cnt;
		logic        bit_tick;
		logic [15:0] fail_func;
		logic [15:0] err_code;
		logic [15:0] fail_reg;
		logic [15:0] last_write;
		logic [15:0] last_read;
		logic [15:0] rdata;
		logic        rvalid;
		led_t        host_led;
		led_t        module_led;
		led_t        network_led;
	} state_t;

	state_t      cur;
	state_t      next_cur;
	logic [7:0]  code;
	logic [15:0] last_reg;
	logic        low_half;
	logic        fs_fault;

	// A file-system fault is held until reset, which stands in for a power cycle.
	// The live input is ORed in so the indicators react without an extra cycle.
	assign fs_fault = cur.fs_latched | status.fs_error;

	// ==========================================================================
	// Classify a failed query into an internal error code.
	// Address-shape faults are checked before drive findings because they are
	// decided locally and do not depend on the drive's answer.
	always_comb begin
		last_reg = query.start_reg + 16'(query.count) - 16'h0001;
		low_half = ((query.start_reg - AREA32_BASE) & 16'h0001) == ZERO16;
		code     = EC_GENERAL;
		if (in_area32(query.start_reg) && query.count == 8'h01 && low_half) begin
			code = EC_LSB_ONLY;
		end else if (in_area32(query.start_reg) && query.count == 8'h01) begin
			code = EC_MSB_ONLY;
		end else if (query.is_write && group_of(query.start_reg) != group_of(last_reg)) begin
			code = EC_GROUP;
		end else if (query.is_write && in_area32(query.start_reg) && query.cause.param16
				&& query.wr_msw != ZERO16) begin
			code = EC_MSB;
		end else if (query.is_write && query.cause.read_only && query.wr_value != ZERO16) begin
			code = EC_RDONLY;
		end else if (query.cause.limit) begin
			code = EC_LIMIT;
		end else if (query.cause.subindex) begin
			code = EC_SUBINDEX;
		end else if (query.cause.dtype) begin
			code = EC_DTYPE;
		end else if (query.cause.timeout) begin
			code = EC_TIMEOUT;
		end
	end

	// ==========================================================================
	// Next state.
	always_comb begin
		next_cur = cur;

		// One shared half-period counter keeps every flashing LED in step.
		if (cur.blink_cnt == 27'(BLINK_COUNT - 1)) begin
			next_cur.blink_cnt = '0;
			next_cur.phase     = ~cur.phase;
		end else begin
			next_cur.blink_cnt = cur.blink_cnt + 27'h0000001;
		end

		// Bit-period tick for the half-duplex frame engine.
		next_cur.bit_tick = 1'b0;
		if (cur.bit_cnt >= divisor(rate_sel)) begin
			next_cur.bit_cnt  = '0;
			next_cur.bit_tick = 1'b1;
		end else begin
			next_cur.bit_cnt = cur.bit_cnt + DIV_W'(1);
		end

		// Host link tracking: establishing until first good, then good or lost.
		case (cur.link)
			HL_ESTABLISH: begin
				if (status.host_up) begin
					next_cur.link = HL_GOOD;
				end
			end
			HL_GOOD: begin
				if (!status.host_up) begin
					next_cur.link = HL_LOST;
				end
			end
			HL_LOST: begin
				if (status.host_up) begin
					next_cur.link = HL_GOOD;
				end
			end
			default: begin
				next_cur.link = HL_ESTABLISH;
			end
		endcase

		// Latch the file-system fault; only reset releases it.
		next_cur.fs_latched = cur.fs_latched | status.fs_error;

		// Master reset command clears first so a query ending in the same
		// cycle overrides it and its outcome is not lost.
		if (reg_req.wr && reg_req.addr == REG_ERR_RESET && reg_req.wdata == RESET_CMD) begin
			next_cur.fail_func = ZERO16;
			next_cur.err_code  = ZERO16;
			next_cur.fail_reg  = ZERO16;
		end
		if (query.done && query.failed) begin
			next_cur.fail_func = {8'h00, query.func};
			next_cur.err_code  = {8'h00, code};
			next_cur.fail_reg  = query.fail_reg;
		end else if (query.done) begin
			next_cur.fail_func = ZERO16;
			next_cur.err_code  = {8'h00, EC_NONE};
			next_cur.fail_reg  = ZERO16;
			if (query.is_write) begin
				next_cur.last_write = query.start_reg;
			end else begin
				next_cur.last_read = query.start_reg;
			end
		end

		// Register read port; the reset register and unmapped numbers read zero.
		next_cur.rvalid = reg_req.rd;
		next_cur.rdata  = ZERO16;
		if (reg_req.rd) begin
			case (reg_req.addr)
				REG_FAIL_FUNC: begin
					next_cur.rdata = cur.fail_func;
				end
				REG_ERR_CODE: begin
					next_cur.rdata = cur.err_code;
				end
				REG_FAIL_REG: begin
					next_cur.rdata = cur.fail_reg;
				end
				REG_LAST_WRITE: begin
					next_cur.rdata = cur.last_write;
				end
				REG_LAST_READ: begin
					next_cur.rdata = cur.last_read;
				end
				default: begin
					next_cur.rdata = ZERO16;
				end
			endcase
		end

		// Host indicator.
		if (fs_fault) begin
			next_cur.host_led = '{green: cur.phase, red: cur.phase};
		end else if (status.config_error) begin
			next_cur.host_led = '{green: 1'b1, red: 1'b1};
		end else if (cur.link == HL_GOOD) begin
			next_cur.host_led = '{green: 1'b1, red: 1'b0};
		end else if (cur.link == HL_LOST) begin
			next_cur.host_led = '{green: 1'b0, red: cur.phase};
		end else begin
			next_cur.host_led = '{green: cur.phase, red: 1'b0};
		end

		// Module indicator; its orange flash runs in the opposite phase.
		if (fs_fault) begin
			next_cur.module_led = '{green: ~cur.phase, red: ~cur.phase};
		end else if (status.config_error) begin
			next_cur.module_led = '{green: 1'b1, red: 1'b1};
		end else if (status.init_busy) begin
			next_cur.module_led = '{green: 1'b0, red: cur.phase};
		end else if (cur.link == HL_LOST) begin
			next_cur.module_led = '{green: 1'b0, red: 1'b0};
		end else begin
			next_cur.module_led = '{green: 1'b1, red: 1'b0};
		end

		// Network indicator.
		if (status.config_error) begin
			next_cur.network_led = '{green: 1'b1, red: 1'b1};
		end else if (status.lines_swapped) begin
			next_cur.network_led = '{green: cur.phase, red: cur.phase};
		end else if (status.parity_error) begin
			next_cur.network_led = '{green: 1'b1, red: ~cur.phase};
		end else if (status.bus_activity) begin
			next_cur.network_led = '{green: cur.phase, red: 1'b0};
		end else begin
			next_cur.network_led = '{green: 1'b0, red: 1'b0};
		end
	end

	// ==========================================================================
	// State register; the link starts in establishing.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cur      <= '0;
			cur.link <= HL_ESTABLISH;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs come straight from state flip-flops.
	assign reg_rdata   = cur.rdata;
	assign reg_rvalid  = cur.rvalid;
	assign bit_tick    = cur.bit_tick;
	assign host_led    = cur.host_led;
	assign module_led  = cur.module_led;
	assign network_led = cur.network_led;

endmodule

`default_nettype wire

//--- inc/fieldbus_diag_pkg.sv
// Purpose: Shared constants and carriers of the fieldbus adapter diagnostics.
// Assumes: One 200 MHz clock; register numbers are 16-bit Modbus numbers.
// Notes:   Register offsets are Modbus holding register numbers.
package fieldbus_diag_pkg;

	// ==========================================================================
	// Timing.
	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned BLINK_MS     = 500;
	localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);

	// ==========================================================================
	// Bit rates in bit/s, indexed by the rate select code.
	localparam int unsigned BAUD_9K6   = 9_600;
	localparam int unsigned BAUD_19K2  = 19_200;
	localparam int unsigned BAUD_38K4  = 38_400;
	localparam int unsigned BAUD_57K6  = 57_600;
	localparam int unsigned BAUD_115K2 = 115_200;
	localparam logic [2:0]  RATE_9K6   = 3'h0;
	localparam logic [2:0]  RATE_19K2  = 3'h1;
	localparam logic [2:0]  RATE_38K4  = 3'h2;
	localparam logic [2:0]  RATE_57K6  = 3'h3;
	localparam logic [2:0]  RATE_115K2 = 3'h4;
	localparam int unsigned DIV_W      = 16;

	// ==========================================================================
	// Register map.
	localparam logic [15:0] REG_ERR_RESET  = 16'h005a;
	localparam logic [15:0] REG_FAIL_FUNC  = 16'h005b;
	localparam logic [15:0] REG_ERR_CODE   = 16'h005c;
	localparam logic [15:0] REG_FAIL_REG   = 16'h005d;
	localparam logic [15:0] REG_LAST_WRITE = 16'h005e;
	localparam logic [15:0] REG_LAST_READ  = 16'h005f;
	localparam logic [15:0] RESET_CMD      = 16'h0001;
	localparam logic [15:0] ZERO16         = 16'h0000;

	// ==========================================================================
	// Parameter address areas.
	localparam logic [15:0] AREA32_BASE = 16'h4e20;  // 20000.
	localparam logic [15:0] AREA32_LAST = 16'h752f;  // 29999.
	localparam logic [15:0] GROUP32_SPAN = 16'h00c8; // 200.
	localparam logic [15:0] GROUP16_SPAN = 16'h0064; // 100.

	// ==========================================================================
	// Internal error codes.
	localparam logic [7:0] EC_NONE     = 8'h00;
	localparam logic [7:0] EC_LIMIT    = 8'h02;
	localparam logic [7:0] EC_SUBINDEX = 8'h03;
	localparam logic [7:0] EC_DTYPE    = 8'h05;
	localparam logic [7:0] EC_GENERAL  = 8'h65;
	localparam logic [7:0] EC_TIMEOUT  = 8'h66;
	localparam logic [7:0] EC_RDONLY   = 8'h70;
	localparam logic [7:0] EC_GROUP    = 8'h71;
	localparam logic [7:0] EC_MSB      = 8'h72;
	localparam logic [7:0] EC_LSB_ONLY = 8'h73;
	localparam logic [7:0] EC_MSB_ONLY = 8'h74;

	// ==========================================================================
	// Carriers.
	typedef enum logic [2:0] {
		HL_ESTABLISH = 3'b001,
		HL_GOOD      = 3'b010,
		HL_LOST      = 3'b100
	} host_link_t;

	typedef struct packed {
		logic green;
		logic red;
	} led_t;

	// Drive-side findings reported with a failed query.
	typedef struct packed {
		logic limit;
		logic subindex;
		logic dtype;
		logic timeout;
		logic read_only;
		logic param16;
	} cause_t;

	// Query outcome from the frame engine; done is a one-cycle pulse.
	typedef struct packed {
		logic        done;
		logic        failed;
		logic        is_write;
		logic [7:0]  func;
		logic [15:0] start_reg;
		logic [7:0]  count;
		logic [15:0] fail_reg;
		logic [15:0] wr_value;
		logic [15:0] wr_msw;
		cause_t      cause;
	} query_t;

	// Master access to the diagnostic registers.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        host_up;
		logic        config_error;
		logic        fs_error;
		logic        init_busy;
		logic        bus_activity;
		logic        parity_error;
		logic        lines_swapped;
	} status_in_t;

endpackage

//--- tb/fieldbus_diag_assertions.sv
// Purpose: Port checks of the fieldbus adapter diagnostics.
// Assumes: BLINK_COUNT matches the instance it is bound to.
// Notes:   Seen only through the top ports.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_diag_assertions #(
	parameter int unsigned BLINK_COUNT = 4
) (
	input wire logic                          clock,
	input wire logic                          rstn,
	input wire fieldbus_diag_pkg::status_in_t status,
	input wire fieldbus_diag_pkg::query_t     query,
	input wire fieldbus_diag_pkg::reg_req_t   reg_req,
	input wire logic [15:0]                   reg_rdata,
	input wire logic                          reg_rvalid,
	input wire logic                          bit_tick,
	input wire fieldbus_diag_pkg::led_t       host_led,
	input wire fieldbus_diag_pkg::led_t       module_led,
	input wire fieldbus_diag_pkg::led_t       network_led
);
	import fieldbus_diag_pkg::*;
	// ==================================================
	// Query outcome followed by a read.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_done(logic f);
		query.done && query.failed == f;
	endsequence
	sequence s_read(logic [15:0] a);
		reg_req.rd && reg_req.addr == a;
	endsequence
	// A cycle with no outcome and no write, so nothing disturbs the words.
	sequence s_quiet;
		!query.done && !reg_req.wr;
	endsequence
	// Mirrors the latched file-system fault, which only reset clears.
	logic fs_seen;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fs_seen <= 1'b0;
		end else if (status.fs_error) begin
			fs_seen <= 1'b1;
		end
	end
	a_fail_func_kept: assert property (s_done(1'b1) ##1 s_quiet ##1 s_read(REG_FAIL_FUNC)
		|=> reg_rdata == {8'h00, $past(query.func, 3)}) else $error("bad func");
	a_ok_clears_code: assert property (s_done(1'b0) ##1 s_quiet ##1 s_read(REG_ERR_CODE)
		|=> reg_rdata == 16'h0000) else $error("code not cleared");
	a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no answer");
	a_no_stray: assert property (!reg_req.rd |=> !reg_rvalid && reg_rdata == 16'h0000)
		else $error("stray answer");
	a_reset_reg_zero: assert property (s_read(REG_ERR_RESET) |=> reg_rdata == 16'h0000)
		else $error("reset word");
	a_config_orange: assert property (status.config_error && !status.fs_error && !fs_seen
		|=> host_led == 2'b11 && module_led == 2'b11) else $error("config led");
	a_net_config: assert property (status.config_error |=> network_led == 2'b11)
		else $error("net config");
	a_fs_alternate: assert property (status.fs_error
		|=> host_led == ~module_led && host_led.green == host_led.red) else $error("fs led");
	a_fs_sticky: assert property (fs_seen
		|=> host_led == ~module_led && host_led.green == host_led.red) else $error("fs not held");
	// Stable crossed lines must flip the indicator every blink period.
	a_swap_blink: assert property ((status.lines_swapped && !status.config_error)[*6]
		|-> network_led != $past(network_led, BLINK_COUNT)) else $error("swap blink");
	a_tick_pulse: assert property (bit_tick |=> !bit_tick) else $error("tick");
endmodule
`default_nettype wire

//--- tb/modbus_master_model.sv
// Purpose: Bus master stand-in issuing query outcomes and register access.
// Assumes: Requests change on the falling clock edge.
// Notes:   A read with no answer returns unknown so the compare fails.
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model (
	input  wire logic                        clock,
	input  wire logic [15:0]                 reg_rdata,
	input  wire logic                        reg_rvalid,
	output var  fieldbus_diag_pkg::query_t   query,
	output var  fieldbus_diag_pkg::reg_req_t reg_req
);
	import fieldbus_diag_pkg::*;
	// Idle from time zero so no strobe precedes reset release.
	initial begin
		query = '0;
		reg_req = '0;
	end
	// One-cycle outcome strobe.
	// Each request is built locally so the port changes once per edge.
	task automatic post(input query_t q);
		query_t p;
		p = q;
		p.done = 1'b1;
		@(negedge clock);
		query = p;
		@(negedge clock);
		query.done = 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_req_t r;
		r = '0;
		r.wr = 1'b1;
		r.addr = a;
		r.wdata = d;
		@(negedge clock);
		reg_req = r;
		@(negedge clock);
		reg_req = '0;
	endtask
	// The answer stands one cycle after the strobe, so it is taken then.
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		reg_req_t r;
		r = '0;
		r.rd = 1'b1;
		r.addr = a;
		@(negedge clock);
		reg_req = r;
		@(negedge clock);
		d = reg_rvalid ? reg_rdata : 16'hxxxx;
		reg_req = '0;
	endtask
endmodule
`default_nettype wire

//--- tb/fieldbus_adapter_diagnostics_bench.sv
// Purpose: Self-checking bench of the fieldbus adapter diagnostics.
// Assumes: Short blink count and a slow model clock rate for bit ticks.
// Notes:   Inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_adapter_diagnostics_bench;
	import fieldbus_diag_pkg::*;
	localparam int unsigned HZ = 1_152_000;
	localparam int unsigned BAUD[6] = '{BAUD_9K6, BAUD_19K2, BAUD_38K4, BAUD_57K6,
		BAUD_115K2, BAUD_9K6};
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	status_in_t  status = '0;
	logic [2:0]  rate_sel = RATE_9K6;
	query_t      query;
	reg_req_t    reg_req;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic        bit_tick;
	led_t        host_led;
	led_t        module_led;
	led_t        network_led;
	logic [15:0] v;
	int          err_total = 0;
	int          n_checks = 0;
	int          k;
	always #2.5 clock = ~clock;
	fieldbus_adapter_diagnostics #(.BLINK_COUNT(4), .CLOCK_HZ(HZ)) dut (
		.clock(clock), .rstn(rstn), .status(status), .rate_sel(rate_sel),
		.query(query), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.bit_tick(bit_tick), .host_led(host_led), .module_led(module_led),
		.network_led(network_led));
	modbus_master_model m (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.query(query), .reg_req(reg_req));
	// ==================================================
	// Compare and report.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		m.rd(a, v);
		chk(v, e);
	endtask
	// Post a failed query, then read back its three failure words.
	task automatic fail(input logic w, input logic [15:0] s, input logic [7:0] n,
		input cause_t c, input logic [15:0] msw, input logic [15:0] val, input logic [7:0] e);
		query_t q;
		q = '0;
		q.failed = 1'b1;
		q.is_write = w;
		q.func = w ? 8'h10 : 8'h03;
		q.start_reg = s;
		q.count = n;
		q.fail_reg = s + 16'h0001;
		q.wr_msw = msw;
		q.wr_value = val;
		q.cause = c;
		m.post(q);
		rchk(REG_FAIL_FUNC, {8'h00, q.func});
		rchk(REG_ERR_CODE, {8'h00, e});
		rchk(REG_FAIL_REG, q.fail_reg);
	endtask
	task automatic okq(input logic w, input logic [15:0] s);
		query_t q;
		q = '0;
		q.is_write = w;
		q.start_reg = s;
		q.count = 8'h01;
		m.post(q);
	endtask
	// Count lit colours of one indicator over two blink periods.
	task automatic lv(input int s, input int eg, input int er);
		led_t l;
		int   g;
		int   r;
		g = 0;
		r = 0;
		repeat (8) begin
			@(negedge clock);
			l = s == 0 ? host_led : s == 1 ? module_led : network_led;
			g += int'(l.green);
			r += int'(l.red);
		end
		chk(16'(g), 16'(eg));
		chk(16'(r), 16'(er));
	endtask
	// Watchdog sized well past the expected run.
	initial begin
		#100000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		fail(1'b0, 16'h4e20, 8'h01, 6'b000000, 16'h0000, 16'h0000, EC_LSB_ONLY);
		fail(1'b0, 16'h4e21, 8'h01, 6'b000000, 16'h0000, 16'h0000, EC_MSB_ONLY);
		fail(1'b1, 16'h0096, 8'h3c, 6'b000000, 16'h0000, 16'h0000, EC_GROUP);
		fail(1'b1, 16'h4e20, 8'h02, 6'b000001, 16'h0001, 16'h0000, EC_MSB);
		fail(1'b1, 16'h012c, 8'h02, 6'b000001, 16'h0001, 16'h0000, EC_GENERAL);
		fail(1'b1, 16'h012c, 8'h01, 6'b000010, 16'h0000, 16'h0005, EC_RDONLY);
		fail(1'b1, 16'h012c, 8'h01, 6'b000010, 16'h0000, 16'h0000, EC_GENERAL);
		fail(1'b1, 16'h012c, 8'h01, 6'b100000, 16'h0000, 16'h0001, EC_LIMIT);
		fail(1'b0, 16'h012c, 8'h01, 6'b010000, 16'h0000, 16'h0000, EC_SUBINDEX);
		fail(1'b1, 16'h012c, 8'h01, 6'b001000, 16'h0000, 16'h0001, EC_DTYPE);
		fail(1'b0, 16'h012c, 8'h01, 6'b000000, 16'h0000, 16'h0000, EC_GENERAL);
		fail(1'b0, 16'h012c, 8'h01, 6'b000100, 16'h0000, 16'h0000, EC_TIMEOUT);
		$display("codes test done");
		okq(1'b1, 16'h0101);
		rchk(REG_ERR_CODE, 16'h0000);
		rchk(REG_LAST_WRITE, 16'h0101);
		okq(1'b0, 16'h0202);
		rchk(REG_LAST_READ, 16'h0202);
		rchk(REG_LAST_WRITE, 16'h0101);
		fail(1'b0, 16'h0202, 8'h01, 6'b000100, 16'h0000, 16'h0000, EC_TIMEOUT);
		m.wr(REG_ERR_RESET, ZERO16);
		rchk(REG_ERR_CODE, {8'h00, EC_TIMEOUT});
		m.wr(REG_FAIL_REG, 16'h1234);
		rchk(REG_FAIL_REG, 16'h0203);
		m.wr(REG_ERR_RESET, RESET_CMD);
		rchk(REG_ERR_CODE, 16'h0000);
		rchk(REG_FAIL_FUNC, 16'h0000);
		rchk(REG_FAIL_REG, 16'h0000);
		rchk(REG_ERR_RESET, 16'h0000);
		rchk(16'h0060, 16'h0000);
		$display("register test done");
		lv(0, 4, 0);
		status.host_up = 1'b1;
		@(negedge clock);
		lv(0, 8, 0);
		lv(1, 8, 0);
		status.host_up = 1'b0;
		@(negedge clock);
		lv(0, 0, 4);
		lv(1, 0, 0);
		status.init_busy = 1'b1;
		@(negedge clock);
		lv(1, 0, 4);
		status = '{fs_error: 1'b1, default: 1'b0};
		@(negedge clock);
		lv(0, 4, 4);
		status = '{config_error: 1'b1, default: 1'b0};
		@(negedge clock);
		lv(2, 8, 8);
		lv(0, 4, 4);
		status = '{lines_swapped: 1'b1, default: 1'b0};
		@(negedge clock);
		lv(2, 4, 4);
		status = '{parity_error: 1'b1, default: 1'b0};
		@(negedge clock);
		lv(2, 8, 4);
		status = '{bus_activity: 1'b1, default: 1'b0};
		@(negedge clock);
		lv(2, 4, 0);
		status = '0;
		@(negedge clock);
		lv(2, 0, 0);
		$display("indicator test done");
		// Two ticks per rate: the first wait may start partway through a bit period.
		for (int i = 0; i < 6; i++) begin
			rate_sel = 3'(i);
			repeat (2) begin
				k = 0;
				do begin
					@(negedge clock);
					k++;
				end while (!bit_tick && k < 300);
			end
			chk(16'(k), 16'(HZ / BAUD[i]));
		end
		$display("rate test done");
		tally_and_finish();
	end
endmodule
bind fieldbus_adapter_diagnostics fieldbus_diag_assertions #(.BLINK_COUNT(BLINK_COUNT)) chk_i (
	.clock(clock), .rstn(rstn), .status(status), .query(query), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bit_tick(bit_tick),
	.host_led(host_led), .module_led(module_led), .network_led(network_led));
`default_nettype wire
